// >>> core/ocsc_output_clock_ctrl.sv
// ocsc_output_clock_ctrl: host registers for one output clock pin and
// the manual frequency-offset words of synthesizers 1 to 4.
// assumes byte-wide host strobes on the system clock; synthesizer
// clocks arrive unsynchronised and run well below half of clock.
`timescale 1ns/1ns

// How it works
// R1 - three-bit field picks the feeding synthesizer
// R2 - halt bits alone never stop the output
// R3 - stopped output held at chosen level
// R4 - tristate bit releases pin after stop
// R5 - divide mode ignores both halt bits
// R6 - stop low waits for falling edge
// R7 - stop high waits for rising edge
// R8 - stop bit halts output without glitch
// R9 - clearing stop resumes without runt pulse
// R10 - enable bit, control resets to 0x01
// R11 - four 40-bit offset words, reset zero
// R12 - offset word is negated signed shift
// R13 - host spaces offset writes by 600 us
// R14 - stop and restart requests act only on sampled clock edges
module ocsc_output_clock_ctrl #(
  parameter int OFFSET_GAP_CYCLES = ocsc_pkg::OCSC_OFFSET_GAP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // host register port
  input wire logic [ocsc_pkg::OCSC_ADDR_W-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // synthesizer clocks and output divider mode
  input wire logic [ocsc_pkg::OCSC_NUM_SYNTH-1:0] synth_clk,
  input wire logic div_mode,
  // output clock pin
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic clk_halted,
  // frequency shifts to synthesizers 1 to 4
  output logic [ocsc_pkg::OCSC_OFFSET_W-1:0] synth1_freq_shift,
  output logic [ocsc_pkg::OCSC_OFFSET_W-1:0] synth2_freq_shift,
  output logic [ocsc_pkg::OCSC_OFFSET_W-1:0] synth3_freq_shift,
  output logic [ocsc_pkg::OCSC_OFFSET_W-1:0] synth4_freq_shift,
  output logic [3:0] offset_load,
  output logic offset_gap_violation
);
  import ocsc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] clock_pin0_control;
  logic [7:0] next_control;
  logic [39:0] offset_word [1:4];
  logic [39:0] next_word [1:4];
  logic [39:0] freq_shift [1:4];
  logic [39:0] next_shift [1:4];
  logic [3:0] next_load;
  logic [7:0] next_rdata;
  logic [15:0] gap_cnt;
  logic [15:0] next_gap_cnt;
  logic next_violation;
  logic [OCSC_NUM_SYNTH-1:0] sync_a;
  logic [OCSC_NUM_SYNTH-1:0] sync_b;
  logic sel_level;
  logic [OCSC_SEL_W-1:0] synth_sel;

  localparam logic [15:0] GAP_LOAD = 16'(OFFSET_GAP_CYCLES - 1);

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  // base address of the offset word of synthesizer n (1 to 4)
  function automatic logic [15:0] word_base(input int n);
    word_base = OCSC_SYNTH1_FREQ_OFFSET
      + 16'((n - 1) * int'(OCSC_OFFSET_BYTES));
  endfunction

  // bit position of a byte; lowest address holds the top byte
  function automatic int byte_pos(input logic [15:0] addr, input int n);
    logic [15:0] k;
    k = addr - word_base(n);
    byte_pos = (4 - int'(k)) * 8;
  endfunction

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // control byte; halt bits are stored only, the gate reads them
  always_comb begin
    next_control = clock_pin0_control;
    if (host_wr && host_addr == OCSC_CLOCK_PIN0_CONTROL) begin
      next_control = host_wdata & OCSC_CTRL_MASK; // R2 R10
    end
  end

  // offset words, byte at a time; the lowest byte commits the shift
  always_comb begin
    next_load = 4'h0;
    for (int n = 1; n <= 4; n++) begin
      next_word[n] = offset_word[n];
      next_shift[n] = freq_shift[n];
      if (host_wr && host_addr >= word_base(n)
          && host_addr < word_base(n) + OCSC_OFFSET_BYTES) begin
        next_word[n][byte_pos(host_addr, n) +: 8] = host_wdata; // R11
        if (host_addr == word_base(n) + OCSC_OFFSET_BYTES - 16'h0001)
        begin
          next_load[n-1] = 1'b1;
          next_shift[n] = -next_word[n]; // R12
        end
      end
    end
  end

  // spacing guard between committed offset words
  always_comb begin
    next_gap_cnt = gap_cnt;
    next_violation = 1'b0;
    if (|next_load) begin
      next_violation = (gap_cnt != 16'h0000); // R13
      next_gap_cnt = GAP_LOAD;
    end else if (gap_cnt != 16'h0000) begin
      next_gap_cnt = gap_cnt - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data one cycle after the strobe, zero when unmapped
  always_comb begin
    next_rdata = 8'h00;
    if (host_rd) begin
      if (host_addr == OCSC_CLOCK_PIN0_CONTROL) begin
        next_rdata = clock_pin0_control;
      end else begin
        for (int n = 1; n <= 4; n++) begin
          if (host_addr >= word_base(n)
              && host_addr < word_base(n) + OCSC_OFFSET_BYTES) begin
            next_rdata = offset_word[n][byte_pos(host_addr, n) +: 8];
          end
        end
      end
    end
  end

  // register file and host-facing flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clock_pin0_control <= OCSC_CTRL_RESET; // R10
      for (int n = 1; n <= 4; n++) begin
        offset_word[n] <= OCSC_OFFSET_RESET; // R11
        freq_shift[n] <= OCSC_OFFSET_RESET;
      end
      offset_load <= 4'h0;
      host_rdata <= 8'h00;
      gap_cnt <= 16'h0000;
      offset_gap_violation <= 1'b0;
    end else begin
      clock_pin0_control <= next_control;
      for (int n = 1; n <= 4; n++) begin
        offset_word[n] <= next_word[n];
        freq_shift[n] <= next_shift[n];
      end
      offset_load <= next_load;
      host_rdata <= next_rdata;
      gap_cnt <= next_gap_cnt;
      offset_gap_violation <= next_violation;
    end
  end

  assign synth1_freq_shift = freq_shift[1];
  assign synth2_freq_shift = freq_shift[2];
  assign synth3_freq_shift = freq_shift[3];
  assign synth4_freq_shift = freq_shift[4];

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // two-flop sampling of every synthesizer clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= synth_clk; // R14
      sync_b <= sync_a;
    end
  end

  // pick the feeding synthesizer; unused codes give a quiet source
  assign synth_sel = clock_pin0_control[OCSC_SEL_LSB +: OCSC_SEL_W];
  always_comb begin
    if (int'(synth_sel) < OCSC_NUM_SYNTH) begin
      sel_level = sync_b[synth_sel]; // R1
    end else begin
      sel_level = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output gate
  // ----------------------------------------------------------------
  ocsc_clock_gate u_gate (
    .clock(clock),
    .nrst(nrst),
    .en(clock_pin0_control[OCSC_EN_BIT]),
    .stop_req(clock_pin0_control[OCSC_STOP_BIT]),
    .halt_high(clock_pin0_control[OCSC_HALT_LEVEL_BIT]),
    .halt_tristate(clock_pin0_control[OCSC_HALT_TRISTATE_BIT]),
    .div_mode(div_mode),
    .src_level(sel_level),
    .pin_out(clk_pin_out),
    .pin_oe(clk_pin_oe),
    .halted(clk_halted)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_SEL_FIRST: assert property ( // R1
    synth_sel == 3'h0 |-> sel_level == sync_b[0])
    else $error("select zero does not pick the first synthesizer");
  AST_SAMPLE_DELAY: assert property ( // R14
    $stable(synth_sel) && synth_sel == 3'h1
      |-> sel_level == $past(synth_clk[1], 2))
    else $error("source not sampled through two flops");
  AST_HALT_STORE_ONLY: assert property ( // R2
    host_wr && host_addr == OCSC_CLOCK_PIN0_CONTROL
      && host_wdata[OCSC_STOP_BIT] == clock_pin0_control[OCSC_STOP_BIT]
      && host_wdata[OCSC_EN_BIT] && clock_pin0_control[OCSC_EN_BIT]
      && !clk_halted && !div_mode && $past(!clk_halted)
      && !clock_pin0_control[OCSC_STOP_BIT]
      |=> !clk_halted)
    else $error("halt bit write changed the output state");
  AST_CTRL_READBACK: assert property ( // R10
    host_rd && host_addr == OCSC_CLOCK_PIN0_CONTROL && !host_wr
      |=> host_rdata == $past(clock_pin0_control))
    else $error("control read returned wrong value");
  AST_SHIFT: assert property ( // R12
    offset_load[0] |-> synth1_freq_shift == -offset_word[1])
    else $error("frequency shift is not the negated offset");
  AST_WORD_WRITE: assert property ( // R11
    host_wr && host_addr == OCSC_SYNTH3_FREQ_OFFSET
      |=> offset_word[3][39:32] == $past(host_wdata))
    else $error("offset top byte not written");
  AST_GAP: assert property ( // R13
    |offset_load ##[1:2] (|offset_load) |-> offset_gap_violation)
    else $error("back to back offset commits not flagged");

endmodule

// >>> core/ocsc_pkg.sv
// ocsc_pkg: register map, field layout, reset values, gate states
// and timing counts for the output clock stop/start control block.
// assumes a byte-wide host register port and a 100 MHz system clock.
package ocsc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int OCSC_ADDR_W = 16;
  localparam logic [15:0] OCSC_SYNTH1_FREQ_OFFSET = 16'h048a;
  localparam logic [15:0] OCSC_SYNTH2_FREQ_OFFSET = 16'h048f;
  localparam logic [15:0] OCSC_SYNTH3_FREQ_OFFSET = 16'h0494;
  localparam logic [15:0] OCSC_SYNTH4_FREQ_OFFSET = 16'h0499;
  localparam logic [15:0] OCSC_CLOCK_PIN0_CONTROL = 16'h04a8;
  localparam logic [15:0] OCSC_OFFSET_BYTES = 16'h0005;
  localparam int OCSC_OFFSET_W = 40;
  localparam int OCSC_NUM_SYNTH = 5;

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int OCSC_EN_BIT = 0;
  localparam int OCSC_STOP_BIT = 1;
  localparam int OCSC_HALT_LEVEL_BIT = 2;
  localparam int OCSC_HALT_TRISTATE_BIT = 3;
  localparam int OCSC_SEL_LSB = 4;
  localparam int OCSC_SEL_W = 3;
  localparam logic [7:0] OCSC_CTRL_RESET = 8'h01;
  localparam logic [7:0] OCSC_CTRL_MASK = 8'h7f;
  localparam logic [39:0] OCSC_OFFSET_RESET = 40'h0000000000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OCSC_CLK_MHZ = 100;
  localparam int OCSC_OFFSET_GAP_US = 600;
  localparam int OCSC_OFFSET_GAP_CYCLES = OCSC_OFFSET_GAP_US * OCSC_CLK_MHZ;

  // ----------------------------------------------------------------
  // output gate states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OCSC_ST_OFF = 3'b001,
    OCSC_ST_RUN = 3'b010,
    OCSC_ST_HALT = 3'b100
  } ocsc_state_e;

endpackage

// >>> core/ocsc_clock_gate.sv
// ocsc_clock_gate: glitch-free stop/start gate for one output clock.
// assumes src_level is the selected synthesizer clock already sampled
// into the system clock domain; all inputs are on that same clock.
`timescale 1ns/1ns
module ocsc_clock_gate (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // configuration
  input wire logic en,
  input wire logic stop_req,
  input wire logic halt_high,
  input wire logic halt_tristate,
  input wire logic div_mode,
  // sampled source clock
  input wire logic src_level,
  // output pin and status
  output logic pin_out,
  output logic pin_oe,
  output logic halted
);
  import ocsc_pkg::*;

  ocsc_state_e state;
  ocsc_state_e next_state;
  logic src_prev;
  logic next_pin_out;
  logic next_pin_oe;
  logic rise;
  logic fall;
  logic stop_edge;
  logic start_edge;

  // edges of the sampled source
  assign rise = src_level & ~src_prev;
  assign fall = ~src_level & src_prev;

  // pick the edge that closes or opens the gate
  always_comb begin
    if (div_mode) begin
      stop_edge = rise | fall; // R5
    end else if (halt_high) begin
      stop_edge = rise; // R7
    end else begin
      stop_edge = fall; // R6
    end
    if (div_mode) begin
      start_edge = rise | fall;
    end else if (pin_out) begin
      start_edge = fall; // R9
    end else begin
      start_edge = rise; // R9
    end
  end

  // gate state, output level and driver enable
  always_comb begin
    next_state = state;
    next_pin_out = pin_out;
    case (state)
      OCSC_ST_OFF: begin
        next_pin_out = 1'b0;
        if (en) begin
          next_state = OCSC_ST_HALT; // R10
        end
      end
      OCSC_ST_RUN: begin
        next_pin_out = src_level;
        if (!en) begin
          next_state = OCSC_ST_OFF;
          next_pin_out = 1'b0;
        end else if (stop_req && stop_edge) begin
          next_state = OCSC_ST_HALT; // R8 R14
        end
      end
      OCSC_ST_HALT: begin
        if (!en) begin
          next_state = OCSC_ST_OFF;
          next_pin_out = 1'b0;
        end else if (!stop_req && start_edge) begin
          next_state = OCSC_ST_RUN; // R9 R14
          next_pin_out = src_level;
        end
      end
      default: begin
        next_state = OCSC_ST_OFF;
        next_pin_out = 1'b0;
      end
    endcase
    if (next_state == OCSC_ST_OFF) begin
      next_pin_oe = 1'b0;
    end else if (next_state == OCSC_ST_HALT) begin
      next_pin_oe = ~(halt_tristate & ~div_mode); // R3 R4 R5
    end else begin
      next_pin_oe = 1'b1;
    end
  end

  // register the gate
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= OCSC_ST_OFF;
      src_prev <= 1'b0;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      halted <= 1'b0;
    end else begin
      state <= next_state;
      src_prev <= src_level;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      halted <= (next_state == OCSC_ST_HALT);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_stop_low;
    state == OCSC_ST_RUN && en && stop_req && !halt_high && !div_mode
      && fall;
  endsequence
  sequence s_stop_high;
    state == OCSC_ST_RUN && en && stop_req && halt_high && !div_mode
      && rise;
  endsequence
  sequence s_resume_low;
    state == OCSC_ST_HALT && en && !stop_req && !div_mode && !pin_out
      && rise;
  endsequence

  AST_STOP_LOW: assert property (s_stop_low |=> // R6
    state == OCSC_ST_HALT && !pin_out ##1 !pin_out || !en || !stop_req)
    else $error("stop low did not rest low after falling edge");
  AST_STOP_HIGH: assert property (s_stop_high |=> // R7
    state == OCSC_ST_HALT && pin_out)
    else $error("stop high did not rest high after rising edge");
  AST_NO_SELF_STOP: assert property ( // R2
    state == OCSC_ST_RUN && !stop_req && en |=> state == OCSC_ST_RUN)
    else $error("output stopped without a stop request");
  AST_RESUME: assert property (s_resume_low |=> // R9
    state == OCSC_ST_RUN && pin_out)
    else $error("restart did not begin on a rising edge");
  AST_RUN_FOLLOWS: assert property ( // R8
    state == OCSC_ST_RUN && $past(state == OCSC_ST_RUN)
      |-> pin_out == $past(src_level))
    else $error("running output does not follow source");
  AST_TRISTATE: assert property ( // R4
    state == OCSC_ST_HALT && $past(state == OCSC_ST_HALT)
      && $past(halt_tristate && !div_mode) |-> !pin_oe)
    else $error("halted output still driven with tristate set");
  AST_HOLD_DRIVEN: assert property ( // R3
    state == OCSC_ST_HALT && $past(state == OCSC_ST_HALT)
      && $past(!halt_tristate) |-> pin_oe && $stable(pin_out))
    else $error("halted output not held at its level");
  AST_DISABLE: assert property (!en |=> // R10
    state == OCSC_ST_OFF && !pin_oe && !pin_out)
    else $error("disabled output still active");

endmodule

// >>> verification/ocsc_clock_load.sv
// ocsc_clock_load: downstream clock load on the output pin; counts
// rising edges and keeps the narrowest full pulse seen while driven.
// assumes pin signals are registered on clock; clr is a bench strobe.
`timescale 1ns/1ns
module ocsc_clock_load (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clr,
  // output pin as seen by the load
  input wire logic pin_out,
  input wire logic pin_oe,
  // observations
  output int rises,
  output int min_w
);
  logic last;
  int w;

  // ----------------------------------------------------------------
  // pulse width monitor
  // ----------------------------------------------------------------
  // partial pulses after clr or release are skipped: w starts negative
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rises <= 0;
      min_w <= 1000;
      w <= -100000;
      last <= 1'b0;
    end else if (clr || !pin_oe) begin
      if (clr) begin
        rises <= 0;
        min_w <= 1000;
      end
      w <= -100000;
      last <= pin_out;
    end else if (pin_out !== last) begin
      if (w > 0 && w < min_w) begin
        min_w <= w;
      end
      if (pin_out) begin
        rises <= rises + 1;
      end
      w <= 1;
      last <= pin_out;
    end else begin
      w <= w + 1;
    end
  end
endmodule

// >>> verification/tb_top.sv
// tb_top: self-checking bench for the output clock control block.
// assumes the load model in ocsc_clock_load and a 20-cycle gap limit.
`timescale 1ns/1ns
module tb_top;
  import ocsc_pkg::*;

  typedef struct {
    logic [7:0] wd;
    logic [7:0] rd;
    int half;
  } ocsc_tb_row_s;

  logic clock, nrst, host_wr, host_rd, div_mode, clr;
  logic [15:0] host_addr;
  logic [7:0] host_wdata, host_rdata, d;
  logic [4:0] synth_clk;
  logic clk_pin_out, clk_pin_oe, clk_halted, offset_gap_violation;
  logic [3:0] offset_load, load_seen;
  logic [39:0] shift [1:4];
  logic [39:0] word [1:4];
  int n_errors, n_tests, rises, min_w, cyc, viol;
  ocsc_tb_row_s rows [8];

  // ----------------------------------------------------------------
  // design, load model, clocks
  // ----------------------------------------------------------------
  ocsc_output_clock_ctrl #(.OFFSET_GAP_CYCLES(20)) u_dut (
    .clock(clock), .nrst(nrst), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .synth_clk(synth_clk),
    .div_mode(div_mode), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .clk_halted(clk_halted),
    .synth1_freq_shift(shift[1]), .synth2_freq_shift(shift[2]),
    .synth3_freq_shift(shift[3]), .synth4_freq_shift(shift[4]),
    .offset_load(offset_load),
    .offset_gap_violation(offset_gap_violation));

  ocsc_clock_load u_load (
    .clock(clock), .nrst(nrst), .clr(clr), .pin_out(clk_pin_out),
    .pin_oe(clk_pin_oe), .rises(rises), .min_w(min_w));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // synthesizer n has a half period of 4+2n system cycles
  always @(negedge clock) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 5; i++) begin
      synth_clk[i] <= ((cyc / (4 + 2 * i)) % 2) == 1;
    end
  end

  // commit pulses and gap flags gathered between checks
  always @(posedge clock) begin
    load_seen <= load_seen | offset_load;
    viol <= viol + int'(offset_gap_violation);
  end

  // ----------------------------------------------------------------
  // host tasks and compares
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clock);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clock);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    v = host_rdata;
    host_rd = 1'b0;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("mismatch at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // bounded wait for the halted flag to reach a level
  task automatic wait_halt(input logic lvl);
    int k;
    k = 0;
    while (clk_halted !== lvl && k < 80) begin
      @(negedge clock);
      k++;
    end
    chk(clk_halted, lvl);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    test_done;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    div_mode = 1'b0;
    clr = 1'b0;
    synth_clk = 5'h00;
    cyc = 0;
    viol = 0;
    load_seen = 4'h0;
    rows = '{'{8'h01, 8'h01, 4}, '{8'h11, 8'h11, 6}, '{8'h21, 8'h21, 8},
             '{8'h31, 8'h31, 10}, '{8'h41, 8'h41, 12}, '{8'h51, 8'h51, 0},
             '{8'hff, 8'h7f, 0}, '{8'h80, 8'h00, 0}};
    word = '{40'h8000000000, 40'h0000000001, 40'hffffffffff,
             40'h123456789a};
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    // reset values and an unmapped place
    rd(OCSC_CLOCK_PIN0_CONTROL, d);
    chk(d, OCSC_CTRL_RESET);
    for (int i = 0; i < 20; i++) begin
      rd(OCSC_SYNTH1_FREQ_OFFSET + 16'(i), d);
      chk(d, 8'h00);
    end
    wr(16'h04a9, 8'h5a);
    rd(16'h04a9, d);
    chk(d, 8'h00);
    $display("test reset done");
    // source select rows: readback and output edge rate
    foreach (rows[r]) begin
      wr(OCSC_CLOCK_PIN0_CONTROL, rows[r].wd);
      rd(OCSC_CLOCK_PIN0_CONTROL, d);
      chk(d, rows[r].rd);
      repeat (30) @(negedge clock);
      clr = 1'b1;
      @(negedge clock);
      clr = 1'b0;
      repeat (120) @(negedge clock);
      if (rows[r].half > 0) begin
        chk_rng(rises, 60 / rows[r].half - 1, 60 / rows[r].half + 1);
        chk_rng(min_w, rows[r].half, 1000);
      end else begin
        chk_rng(rises, 0, 0);
      end
    end
    chk({clk_pin_oe, clk_pin_out}, 2'b00);
    $display("test select done");
    // stop low, restart, stop high, restart on synthesizer 0
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h01);
    wait_halt(1'b1);
    wait_halt(1'b0);
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h03);
    wait_halt(1'b1);
    repeat (30) @(negedge clock);
    chk({clk_halted, clk_pin_oe, clk_pin_out}, 3'b110);
    chk({clk_halted, clk_pin_oe, clk_pin_out}, 3'b110);
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h01);
    wait_halt(1'b0);
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h07);
    wait_halt(1'b1);
    repeat (30) @(negedge clock);
    chk({clk_pin_oe, clk_pin_out}, 2'b11);
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h05);
    wait_halt(1'b0);
    repeat (40) @(negedge clock);
    chk_rng(min_w, 4, 1000);
    $display("test stop done");
    // halt bits alone must not stop the clock
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h0d);
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    repeat (60) @(negedge clock);
    chk({clk_halted, clk_pin_oe}, 2'b01);
    chk_rng(rises, 5, 10);
    // tristate after stop, then divide mode keeps the driver on
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h0b);
    wait_halt(1'b1);
    repeat (10) @(negedge clock);
    chk(clk_pin_oe, 1'b0);
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h01);
    wait_halt(1'b0);
    chk(clk_pin_oe, 1'b1);
    div_mode = 1'b1;
    wr(OCSC_CLOCK_PIN0_CONTROL, 8'h0b);
    wait_halt(1'b1);
    repeat (10) @(negedge clock);
    chk(clk_pin_oe, 1'b1);
    div_mode = 1'b0;
    $display("test halt mode done");
    // offset words, spaced beyond the gap, then one too soon
    for (int n = 1; n <= 4; n++) begin
      load_seen = 4'h0;
      for (int i = 0; i < 5; i++) begin
        wr(OCSC_SYNTH1_FREQ_OFFSET + 16'(5 * (n - 1) + i),
           word[n][39 - 8 * i -: 8]);
      end
      repeat (4) @(negedge clock);
      chk(load_seen, 4'h1 << (n - 1));
      chk(shift[n], ~word[n] + 40'h1);
      for (int i = 0; i < 5; i++) begin
        rd(OCSC_SYNTH1_FREQ_OFFSET + 16'(5 * (n - 1) + i), d);
        chk(d, word[n][39 - 8 * i -: 8]);
      end
      repeat (30) @(negedge clock);
    end
    chk_rng(viol, 0, 0);
    for (int i = 0; i < 5; i++) begin
      wr(OCSC_SYNTH4_FREQ_OFFSET + 16'(i), 8'h00);
    end
    wr(OCSC_SYNTH4_FREQ_OFFSET + 16'h0004, 8'h00);
    repeat (4) @(negedge clock);
    chk_rng(viol, 1, 1);
    $display("test offset done");
    test_done;
  end
endmodule
